// *** dma_pkg.sv ***
// dma_pkg: shared constants and types
// assumes a single 25 MHz system clock and synchronous active-low reset
package dma_pkg;
   localparam int NUM_EVT_CH      = 64;
   localparam int NUM_QCH         = 8;
   localparam int NUM_SETS        = 128;
   localparam int SET_WORDS       = 8;
   localparam int QUEUE_DEPTH     = 16;
   localparam int MAX_INFLIGHT    = 4;
   localparam int DATA_W          = 64;
   localparam int ADDR_W          = 32;
   localparam int SET_IDX_W       = 7;
   localparam int CH_IDX_W        = 6;
   localparam int WORD_IDX_W      = 3;
   localparam int CNT_W           = 16;
   // ------------------------------------------------------------------
   // parameter set word layout
   // ------------------------------------------------------------------
   localparam logic [2:0] W_OPT     = 3'h0;
   localparam logic [2:0] W_SRC     = 3'h1;
   localparam logic [2:0] W_CNT     = 3'h2;   // [15:0] a count, [31:16] b count
   localparam logic [2:0] W_DST     = 3'h3;
   localparam logic [2:0] W_BIDX    = 3'h4;   // [15:0] src b index, [31:16] dst b index
   localparam logic [2:0] W_LINK    = 3'h5;   // [6:0] link set, [31:16] b reload
   localparam logic [2:0] W_CIDX    = 3'h6;   // [15:0] src c index, [31:16] dst c index
   localparam logic [2:0] W_CCNT    = 3'h7;   // [15:0] c count
   localparam int OPT_SAM     = 0;  // 1: source address constant
   localparam int OPT_DAM     = 1;  // 1: destination address constant
   localparam int OPT_SYNCDIM = 2;  // 0: one array per event, 1: a frame
   localparam int OPT_LINKEN  = 3;
   localparam int OPT_CHAINEN = 4;
   localparam int OPT_CHAINLO = 8;  // [13:8] chain target channel
   localparam logic [6:0] LINK_NULL = 7'h7F;
   localparam logic [2:0] QTRIG_RESET = 3'h7;
   localparam logic [63:0] RESERVED_CH_MASK = 64'hFF00_0000_0100_3000;
   localparam logic [1:0] ERR_NONE = 2'h0;
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_LOAD  = 3'b001,
      S_ISSUE = 3'b010,
      S_WAIT  = 3'b011,
      S_WBACK = 3'b100,
      S_LINK  = 3'b101
   } seq_state_t;
endpackage : dma_pkg

// *** dma_controller.sv ***
// dma_controller: channel manager with event latching, two queues,
// parameter set memory, and two transfer engines issuing 64-bit moves
// assumes peripheral events are asynchronous pulses/levels and slaves
// answer every read/write request with a one-cycle ack on the same clock
// Notes on behaviour
// - sixty-four event channels plus eight quick channels
// - 128 sets of eight 32-bit words
// - sets 0-63 per channel; rest quick/link
// - one-dimension sync: one array per event
// - two-dimension sync: whole frame per event
// - three dimensions; self-chaining finishes on one event
// - separate indexes; increment or constant addressing
// - exhausted set reloads from named link set
// - channel starts by event, set write, chain
// - quick channel fires on trigger word write
// - software picks each quick channel's set
// - events latch even when enable is clear
// - channel event sources fixed, except multiplexed
// - two sixteen-entry queues with programmable priority
// - 64-bit ports, at most four requests in flight
// - engines do 2-D; manager sequences third
// - completion/error interrupts; watermark and error status
// - channels 0-7: timer, audio, video sources
// - channels 8-9 muxed audio or timer
// - channels 10-31 serial and card sources, except 12, 13 and 24, which are reserved and tied off
// - channels 25, 32-47 gpio event sources
// - channels 48-55 timers and pwm
// - each engine is its own bus master
`timescale 1ns/1ps
`default_nettype none
module dma_controller
   import dma_pkg::*;
#(
   parameter int QDEPTH = QUEUE_DEPTH
)(
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   input  wire logic [NUM_EVT_CH-1:0] periph_evt,
   input  wire logic [3:0]            mux_evt,
   input  wire logic [1:0]            event_source_select,
   input  wire logic [NUM_EVT_CH-1:0] event_enable,
   input  wire logic [NUM_EVT_CH-1:0] event_set,
   input  wire logic [NUM_EVT_CH-1:0] event_clear,
   input  wire logic                  set_wr,
   input  wire logic [SET_IDX_W-1:0]  set_wr_idx,
   input  wire logic [2:0]            set_wr_word,
   input  wire logic [31:0]           set_wr_data,
   input  wire logic [NUM_QCH*SET_IDX_W-1:0] quick_channel_map,
   input  wire logic [NUM_QCH*3-1:0]  quick_channel_trig,
   input  wire logic [NUM_QCH-1:0]    quick_channel_enable,
   input  wire logic [1:0]            queue_select_hi,
   input  wire logic                  queue1_first,
   input  wire logic [1:0]            eng_ack,
   input  wire logic [1:0]            eng_err,
   output logic [1:0]                 eng_req,
   output logic [1:0]                 eng_we,
   output logic [2*ADDR_W-1:0]        eng_addr,
   output logic [2*DATA_W-1:0]        eng_wdata,
   input  wire logic [2*DATA_W-1:0]   eng_rdata,
   output logic [NUM_EVT_CH-1:0]      event_latch,
   output logic [NUM_EVT_CH-1:0]      done_status,
   output logic                       done_irq,
   output logic                       err_irq,
   output logic [1:0]                 err_status,
   output logic [9:0]                 queue_watermark,
   output logic [1:0]                 queue_overflow
);
   // ------------------------------------------------------------------
   // event synchronisers and source map
   // ------------------------------------------------------------------
   logic [NUM_EVT_CH-1:0] evt_s1, evt_s2;
   logic [3:0]            mux_s1, mux_s2;
   always_ff @(posedge mclk) begin
      evt_s1 <= periph_evt;
      evt_s2 <= evt_s1;
      mux_s1 <= mux_evt;
      mux_s2 <= mux_s1;
   end
   // 8/9: audio port 2 or timer 3
   wire [NUM_EVT_CH-1:0] raw_src;
   assign raw_src[7:0]   = evt_s2[7:0];
   assign raw_src[8]     = event_source_select[0] ? mux_s2[2] : mux_s2[0];
   assign raw_src[9]     = event_source_select[1] ? mux_s2[3] : mux_s2[1];
   assign raw_src[31:10] = evt_s2[31:10];
   assign raw_src[47:32] = evt_s2[47:32];
   assign raw_src[63:48] = evt_s2[63:48];
   // fixed, no remap; reserved lines tied off
   wire [NUM_EVT_CH-1:0] hw_src  = raw_src & ~RESERVED_CH_MASK;
   logic [NUM_EVT_CH-1:0] src_d;
   always_ff @(posedge mclk) begin
      if (!rst_b) src_d <= '0;
      else        src_d <= hw_src;
   end
   wire [NUM_EVT_CH-1:0] hw_rise = hw_src & ~src_d;
   // ------------------------------------------------------------------
   // event latch: set wins over clear
   // ------------------------------------------------------------------
   logic [NUM_EVT_CH-1:0] chain_hit;
   logic [NUM_EVT_CH-1:0] taken;
   wire [NUM_EVT_CH-1:0] evt_in = hw_rise | event_set | chain_hit;
   wire [NUM_EVT_CH-1:0] next_latch = (event_latch & ~event_clear & ~taken) | evt_in;
   always_ff @(posedge mclk) begin
      if (!rst_b) event_latch <= '0;
      else        event_latch <= next_latch;
   end
   // lowest pending channel wins
   wire [NUM_EVT_CH-1:0] pend = event_latch & event_enable;
   function automatic logic [CH_IDX_W:0] first_one(input logic [NUM_EVT_CH-1:0] v);
      logic [CH_IDX_W:0] r;
      r = {1'b1, {CH_IDX_W{1'b0}}};
      for (int i = NUM_EVT_CH-1; i >= 0; i--) begin
         if (v[i]) r = {1'b0, CH_IDX_W'(i)};
      end
      return r;
   endfunction
   wire [CH_IDX_W:0] pick = first_one(pend);
   wire              pick_ok = !pick[CH_IDX_W];
   wire [CH_IDX_W-1:0] pick_ch = pick[CH_IDX_W-1:0];
   wire              pick_q = queue_select_hi[pick_ch[0]];
   // ------------------------------------------------------------------
   // quick channels: trigger word write submits mapped set
   // ------------------------------------------------------------------
   logic [NUM_QCH-1:0] qpend;
   logic [NUM_QCH-1:0] qtaken;
   logic [NUM_QCH-1:0] qhit;
   always_comb begin
      for (int q = 0; q < NUM_QCH; q++) begin
         qhit[q] = set_wr && quick_channel_enable[q]
                   && set_wr_idx == quick_channel_map[q*SET_IDX_W +: SET_IDX_W]
                   && set_wr_word == quick_channel_trig[q*3 +: 3];
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) qpend <= '0;
      else        qpend <= (qpend & ~qtaken) | qhit;
   end
   wire [CH_IDX_W:0] qpick = first_one({{(NUM_EVT_CH-NUM_QCH){1'b0}}, qpend});
   wire [2:0]        qpick_ch = qpick[2:0];
   // ------------------------------------------------------------------
   // two queues of set indexes, sixteen deep
   // ------------------------------------------------------------------
   logic [SET_IDX_W-1:0] qmem [2][QDEPTH];
   logic [4:0] qcount [2];
   logic [3:0] qwr [2];
   logic [3:0] qrd [2];
   logic [1:0] qpop;
   wire qfull0 = qcount[0] == 5'(QDEPTH);
   wire qfull1 = qcount[1] == 5'(QDEPTH);
   wire q_in_full = pick_q ? qfull1 : qfull0;
   // quick channels take priority for the enqueue slot
   wire use_quick = !qpick[CH_IDX_W];
   wire [SET_IDX_W-1:0] push_set = use_quick
        ? quick_channel_map[qpick_ch*SET_IDX_W +: SET_IDX_W]
        : {1'b0, pick_ch};
   wire push_q   = use_quick ? qpick_ch[0] : pick_q;
   wire push_ok  = use_quick ? !(push_q ? qfull1 : qfull0) : pick_ok && !q_in_full;
   always_comb begin
      taken  = '0;
      qtaken = '0;
      if (push_ok && use_quick) qtaken[qpick_ch] = 1'b1;
      if (push_ok && !use_quick) taken[pick_ch] = 1'b1;
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int k = 0; k < 2; k++) begin
            qcount[k] <= '0;
            qwr[k]    <= '0;
            qrd[k]    <= '0;
         end
         queue_watermark <= '0;
         queue_overflow  <= '0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (push_ok && push_q == k[0]) begin
               qmem[k][qwr[k]] <= push_set;
               qwr[k] <= qwr[k] + 4'h1;
            end
            if (qpop[k]) qrd[k] <= qrd[k] + 4'h1;
            qcount[k] <= qcount[k] + 5'(push_ok && push_q == k[0]) - 5'(qpop[k]);
            if (qcount[k] > queue_watermark[k*5 +: 5])
               queue_watermark[k*5 +: 5] <= qcount[k];
            if (!push_ok && (pick_ok || use_quick)) queue_overflow[push_q] <= 1'b1;
         end
      end
   end
   // ------------------------------------------------------------------
   // parameter set memory, one shared write port for software
   // ------------------------------------------------------------------
   logic [31:0] set_mem [NUM_SETS*SET_WORDS];
   function automatic logic [9:0] waddr(input logic [SET_IDX_W-1:0] s, input logic [2:0] w);
      return {s, w};
   endfunction
   // ------------------------------------------------------------------
   // engines: each a 2-D sequencer; c dimension by re-request
   // ------------------------------------------------------------------
   seq_state_t st [2];
   logic [SET_IDX_W-1:0] cur_set [2];
   logic [2:0]  ld_w [2];
   logic [31:0] prm [2][SET_WORDS];
   logic [CNT_W-1:0] acnt [2];
   logic [2:0]  infl [2];
   logic [NUM_EVT_CH-1:0] chain_req [2];
   logic [1:0]  done_ev, err_ev, fin;
   logic [1:0]  wb_we;
   logic [9:0]  wb_addr [2];
   logic [31:0] wb_data [2];
   wire  prio_eng = queue1_first;
   always_ff @(posedge mclk) begin
      if (set_wr)        set_mem[waddr(set_wr_idx, set_wr_word)] <= set_wr_data;
      else if (wb_we[prio_eng]) set_mem[wb_addr[prio_eng]] <= wb_data[prio_eng];
      else if (wb_we[!prio_eng]) set_mem[wb_addr[!prio_eng]] <= wb_data[!prio_eng];
   end
   always_comb begin
      chain_hit = chain_req[0] | chain_req[1];
   end
   for (genvar e = 0; e < 2; e++) begin : g_eng
      wire [31:0] opt   = prm[e][W_OPT];
      wire [CNT_W-1:0] a_len = prm[e][W_CNT][15:0];
      wire [CNT_W-1:0] b_len = prm[e][W_CNT][31:16];
      wire [CNT_W-1:0] c_len = prm[e][W_CCNT][15:0];
      wire [31:0] s_step = opt[OPT_SAM] ? 32'h0 : 32'h8;
      wire [31:0] d_step = opt[OPT_DAM] ? 32'h0 : 32'h8;
      wire last_a = acnt[e] + 16'h8 >= a_len;
      wire last_b = b_len <= 16'h1;
      // one-dim: stop after array; two-dim: after frame
      wire sync_end = last_a && (!opt[OPT_SYNCDIM] || last_b);
      logic rd_phase;
      logic [DATA_W-1:0] hold;
      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            st[e]        <= S_IDLE;
            qpop[e]      <= 1'b0;
            eng_req[e]   <= 1'b0;
            eng_we[e]    <= 1'b0;
            eng_addr[e*ADDR_W +: ADDR_W]  <= '0;
            eng_wdata[e*DATA_W +: DATA_W] <= '0;
            cur_set[e]   <= '0;
            ld_w[e]      <= '0;
            acnt[e]      <= '0;
            fin[e]       <= 1'b0;
            infl[e]      <= '0;
            rd_phase     <= 1'b0;
            hold         <= '0;
            wb_we[e]     <= 1'b0;
            wb_addr[e]   <= '0;
            wb_data[e]   <= '0;
            done_ev[e]   <= 1'b0;
            err_ev[e]    <= 1'b0;
            chain_req[e] <= '0;
         end else begin
            qpop[e]      <= 1'b0;
            wb_we[e]     <= 1'b0;
            done_ev[e]   <= 1'b0;
            err_ev[e]    <= 1'b0;
            chain_req[e] <= '0;
            case (st[e])
               S_IDLE: begin
                  if (qcount[e] != 5'h0 && !qpop[e]) begin
                     cur_set[e] <= qmem[e][qrd[e]];
                     qpop[e]    <= 1'b1;
                     ld_w[e]    <= '0;
                     st[e]      <= S_LOAD;
                  end
               end
               S_LOAD: begin
                  prm[e][ld_w[e]] <= set_mem[waddr(cur_set[e], ld_w[e])];
                  ld_w[e] <= ld_w[e] + 3'h1;
                  if (ld_w[e] == 3'h7) begin
                     acnt[e]  <= '0;
                     rd_phase <= 1'b1;
                     st[e]    <= S_ISSUE;
                  end
               end
               S_ISSUE: begin
                  // read then write per beat
                  if (infl[e] < 3'(MAX_INFLIGHT)) begin
                     eng_req[e] <= 1'b1;
                     eng_we[e]  <= !rd_phase;
                     eng_addr[e*ADDR_W +: ADDR_W] <= rd_phase ? prm[e][W_SRC] : prm[e][W_DST];
                     eng_wdata[e*DATA_W +: DATA_W] <= hold;
                     infl[e] <= infl[e] + 3'h1;
                     st[e] <= S_WAIT;
                  end
               end
               S_WAIT: begin
                  if (eng_ack[e]) begin
                     eng_req[e] <= 1'b0;
                     infl[e]    <= infl[e] - 3'h1;
                     if (eng_err[e]) begin
                        err_ev[e] <= 1'b1;
                        st[e] <= S_IDLE;
                     end else if (rd_phase) begin
                        hold     <= eng_rdata[e*DATA_W +: DATA_W];
                        rd_phase <= 1'b0;
                        st[e]    <= S_ISSUE;
                     end else begin
                        rd_phase <= 1'b1;
                        prm[e][W_SRC] <= prm[e][W_SRC] + s_step;
                        prm[e][W_DST] <= prm[e][W_DST] + d_step;
                        acnt[e] <= acnt[e] + 16'h8;
                        if (last_a) begin
                           acnt[e] <= '0;
                           prm[e][W_CNT][31:16] <= last_b ? prm[e][W_LINK][31:16]
                                                          : b_len - 16'h1;
                           fin[e]  <= last_b && c_len <= 16'h1;
                           // b index steps between arrays, c between frames
                           prm[e][W_SRC] <= prm[e][W_SRC]
                              + 32'($signed(last_b ? prm[e][W_CIDX][15:0] : prm[e][W_BIDX][15:0]));
                           prm[e][W_DST] <= prm[e][W_DST]
                              + 32'($signed(last_b ? prm[e][W_CIDX][31:16] : prm[e][W_BIDX][31:16]));
                           if (last_b) prm[e][W_CCNT] <= {16'h0, c_len - 16'h1};
                        end
                        st[e] <= sync_end ? S_WBACK : S_ISSUE;
                     end
                  end
               end
               S_WBACK: begin
                  // whole set saved, so the next event resumes here
                  wb_we[e]   <= 1'b1;
                  wb_addr[e] <= waddr(cur_set[e], ld_w[e]);
                  wb_data[e] <= prm[e][ld_w[e]];
                  ld_w[e]    <= ld_w[e] + 3'h1;
                  if (ld_w[e] == 3'h7 && fin[e]) begin
                     done_ev[e] <= 1'b1;
                     if (opt[OPT_CHAINEN])
                        chain_req[e][opt[OPT_CHAINLO +: CH_IDX_W]] <= 1'b1;
                     st[e]   <= (opt[OPT_LINKEN] && prm[e][W_LINK][6:0] != LINK_NULL)
                                ? S_LINK : S_IDLE;
                  end else if (ld_w[e] == 3'h7) begin
                     // self-chain keeps the rest of the set running
                     if (opt[OPT_CHAINEN] && cur_set[e][6] == 1'b0)
                        chain_req[e][cur_set[e][5:0]] <= 1'b1;
                     st[e] <= S_IDLE;
                  end
               end
               S_LINK: begin
                  // reload from link set
                  wb_we[e]   <= 1'b1;
                  wb_addr[e] <= waddr(cur_set[e], ld_w[e]);
                  wb_data[e] <= set_mem[waddr(prm[e][W_LINK][6:0], ld_w[e])];
                  ld_w[e] <= ld_w[e] + 3'h1;
                  if (ld_w[e] == 3'h7) st[e] <= S_IDLE;
               end
               default: st[e] <= S_IDLE;
            endcase
         end
      end
   end
   // ------------------------------------------------------------------
   // completion and error status
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         done_status <= '0;
         done_irq    <= 1'b0;
         err_irq     <= 1'b0;
         err_status  <= ERR_NONE;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (done_ev[k] && !cur_set[k][6]) done_status[cur_set[k][5:0]] <= 1'b1;
         end
         done_irq   <= |done_ev;
         err_irq    <= |err_ev;
         err_status <= err_status | err_ev;
      end
   end
endmodule // dma_controller
`default_nettype wire

// *** dma_controller_chk.sv ***
// dma_controller_chk: port-level checks bound into dma_controller
// assumes slaves answer with eng_ack and report faults on eng_err
`timescale 1ns/1ps
`default_nettype none
module dma_controller_chk
   import dma_pkg::*;
#(
   parameter int QDEPTH = QUEUE_DEPTH
)(
   input wire logic                  mclk,
   input wire logic                  rst_b,
   input wire logic [NUM_EVT_CH-1:0] event_enable,
   input wire logic [NUM_EVT_CH-1:0] event_set,
   input wire logic [NUM_EVT_CH-1:0] event_clear,
   input wire logic [1:0]            eng_ack,
   input wire logic [1:0]            eng_req,
   input wire logic [1:0]            eng_we,
   input wire logic [2*ADDR_W-1:0]   eng_addr,
   input wire logic [2*DATA_W-1:0]   eng_wdata,
   input wire logic [NUM_EVT_CH-1:0] event_latch,
   input wire logic [NUM_EVT_CH-1:0] done_status,
   input wire logic                  done_irq,
   input wire logic                  err_irq,
   input wire logic [1:0]            err_status,
   input wire logic [9:0]            queue_watermark,
   input wire logic [1:0]            queue_overflow
);
   logic [NUM_EVT_CH-1:0] keep;
   logic [NUM_EVT_CH-1:0] prev_done;
   logic                  irq_seen;
   // disabled channels keep latched events
   always_ff @(posedge mclk) begin
      keep      <= rst_b ? ((event_latch & ~event_clear) | event_set) & ~event_enable : '0;
      prev_done <= done_status;
      irq_seen  <= done_irq;
   end
   a_req_hold_e0: assert property (@(posedge mclk) disable iff (!rst_b)
      eng_req[0] && !eng_ack[0] |=> eng_req[0] && $stable(eng_addr[31:0])
      && $stable(eng_we[0]) && (!eng_we[0] || $stable(eng_wdata[63:0])))
      else $error("engine 0 request moved");
   a_req_hold_e1: assert property (@(posedge mclk) disable iff (!rst_b)
      eng_req[1] && !eng_ack[1] |=> eng_req[1] && $stable(eng_addr[63:32])
      && $stable(eng_we[1]) && (!eng_we[1] || $stable(eng_wdata[127:64])))
      else $error("engine 1 request moved");
   a_latch_kept: assert property (@(posedge mclk) disable iff (!rst_b)
      (event_latch & keep) == keep)
      else $error("disabled channel lost event");
   a_err_recorded: assert property (@(posedge mclk) disable iff (!rst_b)
      err_irq |-> ##[0:1] (err_status != ERR_NONE))
      else $error("error irq without status");
   a_done_irq: assert property (@(posedge mclk) disable iff (!rst_b)
      (done_status & ~prev_done) != '0 |-> (irq_seen || done_irq) or (##1 done_irq))
      else $error("completion without interrupt");
   a_done_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
      (prev_done & ~done_status) == '0)
      else $error("completion status bit fell");
   a_ovf_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
      !$fell(queue_overflow[0]) && !$fell(queue_overflow[1]))
      else $error("queue overflow flag fell");
   a_wmark_bound: assert property (@(posedge mclk) disable iff (!rst_b)
      queue_watermark[4:0] <= QDEPTH && queue_watermark[9:5] <= QDEPTH)
      else $error("watermark above depth");
endmodule // dma_controller_chk
bind dma_controller dma_controller_chk #(.QDEPTH(QDEPTH)) chk_i (.mclk, .rst_b,
   .event_enable, .event_set, .event_clear, .eng_ack, .eng_req, .eng_we, .eng_addr,
   .eng_wdata, .event_latch, .done_status, .done_irq, .err_irq, .err_status,
   .queue_watermark, .queue_overflow);
`default_nettype wire

// *** dma_mem_model.sv ***
// dma_mem_model: memory slave answering both transfer engines
// assumes requests hold until the one-cycle ack; unwritten words read {a,~a}
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model
   import dma_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                slow,
   input  wire logic                fault,
   input  wire logic [1:0]          eng_req,
   input  wire logic [1:0]          eng_we,
   input  wire logic [2*ADDR_W-1:0] eng_addr,
   input  wire logic [2*DATA_W-1:0] eng_wdata,
   output logic [1:0]               eng_ack,
   output logic [1:0]               eng_err,
   output logic [2*DATA_W-1:0]      eng_rdata
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   int                waited [2];
   logic [ADDR_W-1:0] a;
   initial begin
      eng_ack = '0;
      eng_err = '0;
      eng_rdata = '0;
   end
   // slow mode adds three wait cycles per request
   always @(posedge mclk) begin
      for (int e = 0; e < 2; e++) begin
         a = eng_addr[e*ADDR_W +: ADDR_W];
         // idle data toggles so stale words never pass
         eng_rdata[e*DATA_W +: DATA_W] <= ~eng_rdata[e*DATA_W +: DATA_W];
         eng_ack[e] <= 1'b0;
         eng_err[e] <= 1'b0;
         if (eng_req[e] && !eng_ack[e]) begin
            waited[e] = waited[e] + 1;
            if (waited[e] > (slow ? 3 : 0)) begin
               waited[e] = 0;
               eng_ack[e] <= 1'b1;
               eng_err[e] <= fault;
               if (eng_we[e]) mem[a] = eng_wdata[e*DATA_W +: DATA_W];
               else eng_rdata[e*DATA_W +: DATA_W] <= mem.exists(a) ? mem[a] : {a, ~a};
            end
         end
      end
   end
endmodule // dma_mem_model
`default_nettype wire

// *** tb_top.sv ***
// tb_top: directed tests of the dma controller against a memory slave
// assumes the controller, memory model and bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top import dma_pkg::*; ;
   logic mclk, rst_b, set_wr, queue1_first, slow, fault, done_irq, err_irq;
   logic [63:0]  periph_evt, event_enable, event_set, event_clear, event_latch, done_status, eng_addr;
   logic [127:0] eng_wdata, eng_rdata;
   logic [55:0]  quick_channel_map;
   logic [31:0]  set_wr_data;
   logic [23:0]  quick_channel_trig;
   logic [9:0]   queue_watermark;
   logic [7:0]   quick_channel_enable;
   logic [6:0]   set_wr_idx;
   logic [3:0]   mux_evt;
   logic [2:0]   set_wr_word;
   logic [1:0]   event_source_select, queue_select_hi, eng_ack, eng_err, eng_req, eng_we;
   logic [1:0]   err_status, queue_overflow;
   logic [31:0]  qset [8] = '{32'h0, 32'h5000, 32'h0001_0010, 32'h6000, 32'h0,
                             32'h0000_007F, 32'h0, 32'h1};
   int           failures, check_count;
   dma_controller uut (.mclk, .rst_b, .periph_evt, .mux_evt, .event_source_select,
      .event_enable, .event_set, .event_clear, .set_wr, .set_wr_idx, .set_wr_word,
      .set_wr_data, .quick_channel_map, .quick_channel_trig, .quick_channel_enable,
      .queue_select_hi, .queue1_first, .eng_ack, .eng_err, .eng_req, .eng_we, .eng_addr,
      .eng_wdata, .eng_rdata, .event_latch, .done_status, .done_irq, .err_irq,
      .err_status, .queue_watermark, .queue_overflow);
   dma_mem_model mem_i (.mclk, .slow, .fault, .eng_req, .eng_we, .eng_addr, .eng_wdata,
      .eng_ack, .eng_err, .eng_rdata);
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      #800000;
      failures++;
      final_report;
   end
   function automatic logic [63:0] pat(logic [31:0] a);
      return {a, ~a};
   endfunction
   function automatic logic [63:0] peek(logic [31:0] a);
      return mem_i.mem.exists(a) ? mem_i.mem[a] : 64'h0;
   endfunction
   task automatic check(string what, logic [63:0] exp, logic [63:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // strobe held high over all eight words
   task automatic put_set(logic [6:0] idx, logic [31:0] w [8]);
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         {set_wr, set_wr_idx, set_wr_word, set_wr_data} <= {1'b1, idx, 3'(i), w[i]};
      end
      @(posedge mclk) set_wr <= 1'b0;
   endtask
   task automatic pulse(int ch);
      @(posedge mclk) event_set[ch] <= 1'b1;
      @(posedge mclk) event_set[ch] <= 1'b0;
   endtask
   task automatic settle;
      int quiet;
      quiet = 0;
      for (int i = 0; i < 2000 && quiet < 40; i++) begin
         @(posedge mclk);
         quiet = (eng_req === 2'h0) ? quiet + 1 : 0;
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {rst_b, set_wr, queue1_first, slow, fault} = '0;
      {periph_evt, event_enable, event_set, event_clear} = '0;
      {mux_evt, event_source_select, set_wr_idx, set_wr_word, set_wr_data} = '0;
      {quick_channel_map, quick_channel_trig, quick_channel_enable} = '0;
      queue_select_hi = 2'h2;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      #1 check("reset status", 64'h0, event_latch | done_status | {err_status, queue_overflow});
      pulse(20);
      repeat (20) @(posedge mclk);
      #1 check("latch while disabled", 64'h1 << 20, event_latch);
      check("no request", 64'h0, {62'h0, eng_req});
      @(posedge mclk) event_clear[20] <= 1'b1;
      @(posedge mclk) event_clear[20] <= 1'b0;
      $display("test latch done");
      @(posedge mclk) event_enable[5] <= 1'b1;
      put_set(7'h05, '{32'h0, 32'h1000, 32'h0002_0010, 32'h2000, 32'h0010_0010,
                       32'h0002_007F, 32'h0, 32'h1});
      pulse(5);
      settle;
      check("first array", pat(32'h1008), peek(32'h2008));
      check("one array per event", 64'h0, peek(32'h2010));
      pulse(5);
      settle;
      check("second array", pat(32'h1018), peek(32'h2018));
      check("channel done", 64'h20, done_status);
      $display("test array sync done");
      @(posedge mclk) {event_enable[3], slow, queue1_first} <= 3'h7;
      put_set(7'h03, '{32'h6, 32'h3000, 32'h0002_0010, 32'h4000, 32'h0000_0010,
                       32'h0000_007F, 32'h0, 32'h1});
      @(posedge mclk) periph_evt[3] <= 1'b1;
      repeat (4) @(posedge mclk);
      periph_evt[3] <= 1'b0;
      settle;
      check("frame on one event", pat(32'h3020), peek(32'h4000));
      check("constant destination", 64'h0, peek(32'h4008));
      $display("test frame sync done");
      @(posedge mclk) {quick_channel_map[13:7], quick_channel_trig[5:3]} <= {7'h46, 3'h7};
      quick_channel_enable[1] <= 1'b1;
      put_set(7'h46, qset);
      settle;
      check("quick channel copy", pat(32'h5008), peek(32'h6008));
      $display("test quick channel done");
      @(posedge mclk) {event_source_select, mux_evt} <= {2'h1, 4'h6};
      {periph_evt[12], periph_evt[60]} <= 2'h3;
      repeat (8) @(posedge mclk);
      #1 check("event sources", 64'h300, event_latch);
      $display("test event sources done");
      @(posedge mclk) fault <= 1'b1;
      put_set(7'h46, qset);
      settle;
      check("error recorded", 64'h1, {63'h0, err_status != ERR_NONE});
      $display("test error done");
      final_report;
   end
endmodule // tb_top
`default_nettype wire
